// [rtl/fdc_regs_top.sv]
// Function
// - Five-bit soft turn-off angle at full duty, 1.4 to 45 degrees, default 31.
// - Zero-crossing phase-lock bit is only stored and read back, no logic uses it, default on.
// - Two-bit stall ratio picks 0.6s off against 1.8 to 3.6s detect.
// - Stall off-time timer also sets the overload retry interval.
// - Current zero-cross rise lags Hall rise by code degrees, one per step.
// - Soft transition angles apply only while soft switching is enabled.
`timescale 1ns/1ps
`include "fdc_defs.svh"
module fdc_regs_top #(
    parameter int OFF_CYCLES = `FDC_OFF_CYCLES,
    parameter int ADDR_W     = 8
) (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              otpLoad,
    input  wire fdc_pkg::fdc_cfg_t otpCfg,
    input  wire logic              softSwitchEnable,
    input  wire logic              hallRaw,
    input  wire logic              overloadRaw,
    output fdc_pkg::fdc_cfg_t      cfg,
    output logic                   factoryMode,
    output logic                   softOffActive,
    output logic      [12:0]       softOffAngleCdeg,
    output logic                   programUnlocked,
    output logic                   currentZeroCross,
    output logic                   driveOff,
    output logic                   stallFault
);
    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic [1:0] sync1_reg;
    logic [1:0] sync2_reg;
    logic [1:0] sync3_reg;
    logic [1:0] clean_reg;
    logic       hallPrev_reg;
    wire  [1:0] pinRaw;
    wire        hallClean;
    wire        overloadClean;
    wire        hallRisePulse;

    assign pinRaw = {overloadRaw, hallRaw};

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gSync
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    sync1_reg[g] <= 1'b0;
                    sync2_reg[g] <= 1'b0;
                    sync3_reg[g] <= 1'b0;
                    clean_reg[g] <= 1'b0;
                end else begin
                    sync1_reg[g] <= pinRaw[g];
                    sync2_reg[g] <= sync1_reg[g];
                    sync3_reg[g] <= sync2_reg[g];
                    if (sync2_reg[g] == sync3_reg[g]) begin
                        clean_reg[g] <= sync3_reg[g];
                    end
                end
            end
        end
    endgenerate

    assign hallClean     = clean_reg[0];
    assign overloadClean = clean_reg[1];
    assign hallRisePulse = hallClean && !hallPrev_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hallPrev_reg <= 1'b0;
        end else begin
            hallPrev_reg <= hallClean;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB decode

    logic [1:0] rsvdLow_reg;
    wire  [5:0] regIdx;
    wire        aligned;
    wire        setupPhase;
    wire        accessDone;
    wire        wrDone;
    wire        hitSoff;
    wire        hitLockCfg;
    wire        hitFactory;
    wire        hitUnlock;
    wire        hitRsvd;
    wire        hitStatus;
    wire        mapped;
    wire [31:0] rdSoff;
    wire [31:0] rdLockCfg;
    wire [31:0] rdFactory;
    wire [31:0] rdStatus;
    wire [31:0] rdMux;

    assign regIdx     = paddr[7:2];
    assign aligned    = paddr[1:0] == 2'h0;
    assign setupPhase = psel && !penable;
    assign accessDone = psel && penable && pready;
    assign wrDone     = accessDone && pwrite && !pslverr;

    assign hitSoff    = aligned && regIdx == `FDC_IDX_SOFF;
    assign hitLockCfg = aligned && regIdx == `FDC_IDX_LOCKCFG;
    assign hitFactory = aligned && regIdx == `FDC_IDX_FACTORY;
    assign hitUnlock  = aligned && regIdx == `FDC_IDX_UNLOCK;
    assign hitRsvd    = aligned && (regIdx == `FDC_IDX_RSVD_A
                                 || regIdx == `FDC_IDX_RSVD_B);
    assign hitStatus  = aligned && regIdx == `FDC_IDX_STATUS;
    assign mapped     = hitSoff || hitLockCfg || hitFactory
                     || hitUnlock || hitRsvd || hitStatus;

    assign rdSoff    = {27'h0, cfg.softOffCode};
    assign rdLockCfg = {25'h0, cfg.zeroCrossLockEnable,
                        cfg.stallRatioSelect, cfg.hallToCurrentDelay};
    assign rdFactory = {29'h0, factoryMode, rsvdLow_reg};
    assign rdStatus  = {26'h0, softOffActive, hallClean, stallFault,
                        driveOff, factoryMode, programUnlocked};

    assign rdMux = hitSoff    ? rdSoff    :
                   hitLockCfg ? rdLockCfg :
                   hitFactory ? rdFactory :
                   hitStatus  ? rdStatus  : 32'h0;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else begin
            pready  <= setupPhase;
            pslverr <= setupPhase && !mapped;
            prdata  <= (setupPhase && !pwrite) ? rdMux : 32'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers

    fdc_pkg::fdc_cfg_t cfg_next;
    logic              fm_next;
    logic [1:0]        rsvd_next;
    logic              unlock_next;

    always_comb begin
        cfg_next = cfg;
        if (otpLoad) begin
            cfg_next = otpCfg;
        end
        if (wrDone && hitSoff) begin
            cfg_next.softOffCode = pwdata[`FDC_SOFF_HI:0];
        end
        if (wrDone && hitLockCfg) begin
            cfg_next.zeroCrossLockEnable = pwdata[`FDC_ZCL_BIT];
            cfg_next.stallRatioSelect    =
                pwdata[`FDC_STALL_HI:`FDC_STALL_LO];
            cfg_next.hallToCurrentDelay  = pwdata[`FDC_DELAY_HI:0];
        end
    end

    assign fm_next     = (wrDone && hitFactory) ? pwdata[`FDC_FM_BIT]
                                                : factoryMode;
    assign rsvd_next   = (wrDone && hitFactory) ? pwdata[`FDC_RSVD_HI:0]
                                                : rsvdLow_reg;
    assign unlock_next = (wrDone && hitUnlock)
                       ? (pwdata[7:0] == `FDC_UNLOCK_KEY) : programUnlocked;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg.softOffCode         <= `FDC_RST_SOFF;
            cfg.zeroCrossLockEnable <= `FDC_RST_ZCL;
            cfg.stallRatioSelect    <= `FDC_RST_STALL;
            cfg.hallToCurrentDelay  <= `FDC_RST_DELAY;
            factoryMode             <= `FDC_RST_FM;
            rsvdLow_reg             <= `FDC_RST_RSVD;
            programUnlocked         <= 1'b0;
        end else begin
            cfg             <= cfg_next;
            factoryMode     <= fm_next;
            rsvdLow_reg     <= rsvd_next;
            programUnlocked <= unlock_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Soft turn-off angle

    wire [31:0] angleWide;
    wire [12:0] angleCdeg;

    assign angleWide = `FDC_ANG_MIN_CDEG + (int'(cfg.softOffCode)
                     * `FDC_ANG_SPAN_CDEG) / `FDC_ANG_STEPS;
    assign angleCdeg = angleWide[12:0];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            softOffActive    <= 1'b0;
            softOffAngleCdeg <= 13'h0;
        end else begin
            softOffActive    <= softSwitchEnable;
            softOffAngleCdeg <= softSwitchEnable ? angleCdeg : 13'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Hall delay and stall timer

    fdc_hall_delay #(
        .CNT_W      (24)
    ) uHallDelay (
        .clk        (clk),
        .rst_n      (rst_n),
        .hallLevel  (hallClean),
        .delayCode  (cfg.hallToCurrentDelay),
        .zeroCross  (currentZeroCross)
    );

    fdc_stall_timer #(
        .OFF_CYCLES    (OFF_CYCLES),
        .CNT_W         (32)
    ) uStall (
        .clk           (clk),
        .rst_n         (rst_n),
        .motionPulse   (hallRisePulse),
        .overloadEvent (overloadClean),
        .ratioSelect   (cfg.stallRatioSelect),
        .driveOff      (driveOff),
        .lockFault     (stallFault)
    );

endmodule : fdc_regs_top

// [rtl/fdc_defs.svh]
`ifndef FDC_DEFS_SVH
`define FDC_DEFS_SVH

// Register indices, byte address is four times the index
`define FDC_IDX_SOFF      6'h0e
`define FDC_IDX_LOCKCFG   6'h0f
`define FDC_IDX_FACTORY   6'h10
`define FDC_IDX_UNLOCK    6'h11
`define FDC_IDX_RSVD_A    6'h12
`define FDC_IDX_RSVD_B    6'h13
`define FDC_IDX_STATUS    6'h14

// Field positions
`define FDC_SOFF_HI       4
`define FDC_ZCL_BIT       6
`define FDC_STALL_HI      5
`define FDC_STALL_LO      4
`define FDC_DELAY_HI      3
`define FDC_FM_BIT        2
`define FDC_RSVD_HI       1

// Reset values
`define FDC_RST_SOFF      5'h1f
`define FDC_RST_ZCL       1'h1
`define FDC_RST_STALL     2'h3
`define FDC_RST_DELAY     4'h0
`define FDC_RST_FM        1'h0
`define FDC_RST_RSVD      2'h0

// Programming unlock key
`define FDC_UNLOCK_KEY    8'h28

// Timing
`define FDC_CLK_HZ        10000000
`define FDC_OFF_TIME_MS   600
`define FDC_RATIO_BASE    3
`define FDC_OFF_CYCLES    (`FDC_OFF_TIME_MS * (`FDC_CLK_HZ / 1000))
`define FDC_DEG_PER_TURN  360

// Soft angle scale in hundredths of a degree
`define FDC_ANG_MIN_CDEG  140
`define FDC_ANG_SPAN_CDEG 4360
`define FDC_ANG_STEPS     31

`endif

// [rtl/fdc_pkg.sv]
package fdc_pkg;

    typedef struct packed {
        logic [4:0] softOffCode;
        logic       zeroCrossLockEnable;
        logic [1:0] stallRatioSelect;
        logic [3:0] hallToCurrentDelay;
    } fdc_cfg_t;

    typedef enum logic {
        STALL_RUN,
        STALL_OFF
    } fdc_stall_state_t;

endpackage : fdc_pkg

// [rtl/fdc_stall_timer.sv]
`timescale 1ns/1ps
`include "fdc_defs.svh"
module fdc_stall_timer #(
    parameter int OFF_CYCLES = 6000000,
    parameter int CNT_W      = 32
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       motionPulse,
    input  wire logic       overloadEvent,
    input  wire logic [1:0] ratioSelect,
    output logic            driveOff,
    output logic            lockFault
);
    fdc_pkg::fdc_stall_state_t state_reg;
    fdc_pkg::fdc_stall_state_t state_next;
    logic [CNT_W-1:0]          cnt_reg;
    logic [CNT_W-1:0]          cnt_next;
    logic                      fault_next;
    wire  [CNT_W-1:0]          offLimit;
    wire  [CNT_W-1:0]          detectLimit;

    assign offLimit    = CNT_W'(OFF_CYCLES - 1);
    assign detectLimit = CNT_W'(OFF_CYCLES * (`FDC_RATIO_BASE
                         + int'(ratioSelect)) - 1);

    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg + 1'b1;
        fault_next = lockFault;
        unique case (state_reg)
            fdc_pkg::STALL_RUN: begin
                if (overloadEvent) begin
                    state_next = fdc_pkg::STALL_OFF;
                    cnt_next   = '0;
                end else if (motionPulse) begin
                    cnt_next   = '0;
                    fault_next = 1'b0;
                end else if (cnt_reg >= detectLimit) begin
                    state_next = fdc_pkg::STALL_OFF;
                    cnt_next   = '0;
                    fault_next = 1'b1;
                end
            end
            fdc_pkg::STALL_OFF: begin
                if (cnt_reg >= offLimit) begin
                    state_next = fdc_pkg::STALL_RUN;
                    cnt_next   = '0;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= fdc_pkg::STALL_RUN;
            cnt_reg   <= '0;
            driveOff  <= 1'b0;
            lockFault <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            driveOff  <= (state_next == fdc_pkg::STALL_OFF);
            lockFault <= fault_next;
        end
    end
endmodule : fdc_stall_timer

// [rtl/fdc_hall_delay.sv]
`timescale 1ns/1ps
`include "fdc_defs.svh"
module fdc_hall_delay #(
    parameter int CNT_W = 24
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       hallLevel,
    input  wire logic [3:0] delayCode,
    output logic            zeroCross
);
    logic [CNT_W-1:0] period_reg;
    logic [CNT_W-1:0] periodCnt_reg;
    logic [CNT_W-1:0] wait_reg;
    logic             hallPrev_reg;
    logic             target_reg;
    logic             pend_reg;
    wire              hallEdge;
    wire              hallRise;
    wire              periodMax;
    wire  [CNT_W+3:0] scaled;
    wire  [CNT_W-1:0] delayCycles;

    assign hallEdge    = hallLevel != hallPrev_reg;
    assign hallRise    = hallEdge && hallLevel;
    assign periodMax   = &periodCnt_reg;
    assign scaled      = period_reg * delayCode;
    assign delayCycles = CNT_W'(scaled / `FDC_DEG_PER_TURN);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            period_reg    <= '0;
            periodCnt_reg <= '0;
            hallPrev_reg  <= 1'b0;
        end else begin
            hallPrev_reg <= hallLevel;
            if (hallRise) begin
                period_reg    <= periodCnt_reg;
                periodCnt_reg <= {{(CNT_W-1){1'b0}}, 1'b1};
            end else if (!periodMax) begin
                periodCnt_reg <= periodCnt_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            target_reg <= 1'b0;
            pend_reg   <= 1'b0;
            wait_reg   <= '0;
            zeroCross  <= 1'b0;
        end else if (hallEdge) begin
            target_reg <= hallLevel;
            pend_reg   <= 1'b1;
            wait_reg   <= '0;
        end else if (pend_reg && wait_reg >= delayCycles) begin
            zeroCross <= target_reg;
            pend_reg  <= 1'b0;
        end else if (pend_reg) begin
            wait_reg <= wait_reg + 1'b1;
        end
    end
endmodule : fdc_hall_delay

// [bench/fdc_regs_assertions.sv]
`timescale 1ns/1ps
module fdc_regs_assertions #(
    parameter int OFF_CYCLES = 20,
    parameter int ADDR_W     = 8
) (
    input wire logic              clk,
    input wire logic              rst_n,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              softSwitchEnable,
    input wire fdc_pkg::fdc_cfg_t cfg,
    input wire logic [12:0]       softOffAngleCdeg,
    input wire logic              factoryMode,
    input wire logic              programUnlocked,
    input wire logic              driveOff,
    input wire logic              stallFault,
    input wire logic              currentZeroCross
);
    int         offCnt;
    logic [1:0] upCnt;
    wire        wrOk = psel && penable && pready && pwrite && !pslverr;
    wire        badAd = paddr[1:0] != 2'h0 || paddr < 8'h38 || paddr > 8'h50;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            offCnt <= 0;
            upCnt  <= 2'h0;
        end else begin
            offCnt <= driveOff ? offCnt + 1 : 0;
            upCnt  <= (upCnt == 2'h3) ? upCnt : upCnt + 2'h1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////
    property p_ready_one; psel && !penable |=> pready; endproperty
    a_ready_one: assert property (p_ready_one) else $error("late ready");
    property p_ready_acc;
        pready |-> psel && penable && $past(psel && !penable);
    endproperty
    a_ready_acc: assert property (p_ready_acc) else $error("stray ready");
    property p_err_map; pready |-> pslverr == badAd; endproperty
    a_err_map: assert property (p_err_map) else $error("bad error flag");
    property p_soff_wr;
        wrOk && paddr == 8'h38 |=> cfg.softOffCode == $past(pwdata[4:0]);
    endproperty
    a_soff_wr: assert property (p_soff_wr) else $error("soft code");
    property p_lock_wr;
        wrOk && paddr == 8'h3c |=> {cfg.zeroCrossLockEnable,
            cfg.stallRatioSelect, cfg.hallToCurrentDelay} == $past(pwdata[6:0]);
    endproperty
    a_lock_wr: assert property (p_lock_wr) else $error("lock cfg");
    property p_fm_wr;
        wrOk && paddr == 8'h40 |=> factoryMode == $past(pwdata[2]);
    endproperty
    a_fm_wr: assert property (p_fm_wr) else $error("factory bit");
    property p_unlock;
        wrOk && paddr == 8'h44 |=>
            programUnlocked == ($past(pwdata[7:0]) == 8'h28);
    endproperty
    a_unlock: assert property (p_unlock) else $error("unlock");
    property p_soft_zero;
        !$past(softSwitchEnable) && !$past(softSwitchEnable, 2)
            |-> softOffAngleCdeg == 13'h0;
    endproperty
    a_soft_zero: assert property (p_soft_zero) else $error("angle on");
    property p_soft_max;
        upCnt == 2'h3 && $past(softSwitchEnable) && $past(softSwitchEnable, 2)
            && $past(cfg.softOffCode) == 5'h1f
            && $past(cfg.softOffCode, 2) == 5'h1f
            |-> softOffAngleCdeg == 13'h1194;
    endproperty
    a_soft_max: assert property (p_soft_max) else $error("max angle");
    property p_off_len; $fell(driveOff) |-> offCnt == OFF_CYCLES; endproperty
    a_off_len: assert property (p_off_len) else $error("off time");
    property p_fault_off; $rose(stallFault) |-> driveOff && offCnt == 0;
    endproperty
    a_fault_off: assert property (p_fault_off) else $error("fault");
    c_write: cover property (wrOk && paddr == 8'h40);
    c_off: cover property ($rose(driveOff));
    c_zc: cover property ($rose(currentZeroCross));
endmodule : fdc_regs_assertions

bind fdc_regs_top fdc_regs_assertions #(
    .OFF_CYCLES(OFF_CYCLES), .ADDR_W(ADDR_W)
) i_chk (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .softSwitchEnable(softSwitchEnable),
    .cfg(cfg), .softOffAngleCdeg(softOffAngleCdeg),
    .factoryMode(factoryMode), .programUnlocked(programUnlocked),
    .driveOff(driveOff), .stallFault(stallFault),
    .currentZeroCross(currentZeroCross)
);

// [bench/fdc_regs_top_tb.sv]
`timescale 1ns/1ps
module fdc_regs_top_tb;
    localparam int OFF = 400;
    logic              clk = 1'b0;
    logic              rst_n = 1'b0;
    logic              psel = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite = 1'b0;
    logic [7:0]        paddr = 8'h00;
    logic [31:0]       pwdata = 32'h0;
    logic              otpLoad = 1'b0;
    fdc_pkg::fdc_cfg_t otpCfg = '0;
    logic              softSwitchEnable = 1'b0;
    logic              hallRaw = 1'b0;
    logic              overloadRaw = 1'b0;
    logic              hallRun = 1'b0;
    logic [31:0]       prdata;
    logic              pready, pslverr, factoryMode, programUnlocked;
    logic              currentZeroCross, driveOff, stallFault, softOffActive;
    logic [12:0]       softOffAngleCdeg;
    fdc_pkg::fdc_cfg_t cfg;
    logic [4:0]        codes [3] = '{5'h00, 5'h10, 5'h1f};
    logic [12:0]       angs [3] = '{13'h008c, 13'h0956, 13'h1194};
    int                errors = 0, compares = 0, cycles = 0;
    int                hCnt = 0, riseCyc = 0, n, d0;

    always #50 clk = ~clk;

    fdc_regs_top #(.OFF_CYCLES(OFF)) i_dut (
        .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .otpLoad(otpLoad),
        .otpCfg(otpCfg), .softSwitchEnable(softSwitchEnable),
        .hallRaw(hallRaw), .overloadRaw(overloadRaw), .cfg(cfg),
        .factoryMode(factoryMode), .softOffActive(softOffActive),
        .softOffAngleCdeg(softOffAngleCdeg),
        .programUnlocked(programUnlocked),
        .currentZeroCross(currentZeroCross), .driveOff(driveOff),
        .stallFault(stallFault)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        compares++;
        if (g !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic acc(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [31:0] ed,
                       input logic ee);
        int k;
        k = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        chk("pready", 1, pready);
        chk("pslverr", ee, pslverr);
        if (!w) chk("prdata", ed, prdata);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : acc

    task automatic waitLv(input bit zc, input logic lv, output int c);
        c = 0;
        while ((zc ? currentZeroCross : driveOff) !== lv && c < 8000) begin
            @(posedge clk);
            c++;
        end
    endtask : waitLv

    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            errors = errors + 1;
            conclude();
        end
        if (hallRun) begin
            hCnt <= (hCnt == 179) ? 0 : hCnt + 1;
            if (hCnt == 179) begin
                hallRaw <= !hallRaw;
                if (!hallRaw) riseCyc <= cycles;
            end
        end
    end

    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        acc(0, 8'h38, 0, 32'h1f, 0); // default
        acc(0, 8'h3c, 0, 32'h70, 0); // defaults
        acc(0, 8'h40, 0, 32'h00, 0); // default
        acc(0, 8'h44, 0, 32'h00, 0); // reads zero
        acc(1, 8'h48, 32'hff, 0, 0);
        acc(0, 8'h48, 0, 32'h00, 0);
        acc(0, 8'h39, 0, 32'h00, 1);
        acc(1, 8'hfc, 32'hff, 0, 1);
        softSwitchEnable <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            acc(1, 8'h38, {27'h0, codes[i]}, 0, 0);
            repeat (3) @(posedge clk);
            chk("soft angle", angs[i], softOffAngleCdeg); // scale
        end
        chk("soft active", 1, softOffActive); // enabled
        softSwitchEnable <= 1'b0;
        repeat (3) @(posedge clk);
        chk("soft angle off", 0, softOffAngleCdeg); // disabled
        acc(1, 8'h38, 32'hff, 0, 0);
        acc(0, 8'h38, 0, 32'h1f, 0); // field width
        acc(1, 8'h3c, 32'hff, 0, 0);
        acc(0, 8'h3c, 0, 32'h7f, 0); // fields
        acc(1, 8'h40, 32'h04, 0, 0); // zero reserved bits
        #1 chk("factory mode", 1, factoryMode); // set
        acc(1, 8'h40, 32'h00, 0, 0); // zero reserved bits
        #1 chk("factory mode", 0, factoryMode); // clear
        acc(1, 8'h44, 32'h28, 0, 0); // key
        #1 chk("unlocked", 1, programUnlocked); // key taken
        acc(0, 8'h50, 0, 32'h01, 0); // status word
        acc(0, 8'h44, 0, 32'h00, 0); // write only
        acc(1, 8'h44, 32'h27, 0, 0);
        #1 chk("unlocked", 0, programUnlocked); // wrong key
        @(posedge clk);
        otpCfg <= '{5'h0a, 1'b0, 2'h1, 4'h5};
        otpLoad <= 1'b1;
        @(posedge clk);
        otpLoad <= 1'b0;
        #1 chk("cfg loaded", 32'h515, cfg); // load
        acc(0, 8'h3c, 0, 32'h15, 0); // readback
        // Stall detect and off time
        for (int s = 0; s < 4; s += 3) begin
            acc(1, 8'h3c, s << 4, 0, 0);
            waitLv(0, 1, n);
            waitLv(0, 0, n);
            waitLv(0, 1, n);
            chk("stall gap", 1, n >= OFF * (3 + s) - 2
                && n <= OFF * (3 + s) + 2); // ratio
            chk("stall fault", 1, stallFault); // detect
            waitLv(0, 0, n);
            chk("off length", OFF, n); // off time
        end
        // Hall to current delay
        hallRun <= 1'b1;
        for (int c = 0; c < 16; c += 15) begin
            acc(1, 8'h3c, 32'h70 | c, 0, 0);
            repeat (1500) @(posedge clk);
            waitLv(1, 0, n);
            waitLv(1, 1, n);
            if (c == 0) d0 = cycles - riseCyc;
        end
        chk("delay steps", 15, cycles - riseCyc - d0); // degrees
        chk("fault cleared", 0, stallFault); // hall clears
        overloadRaw <= 1'b1;
        repeat (4) @(posedge clk);
        overloadRaw <= 1'b0;
        waitLv(0, 1, n);
        chk("overload off", 1, n < 10); // retry start
        chk("fault kept", 0, stallFault); // no stall flag
        waitLv(0, 0, n);
        chk("retry length", OFF, n); // retry time
        conclude();
    end
endmodule : fdc_regs_top_tb
